// file: core/csm_core.sv
/*
 CPU global state, privilege mode, exception entry and operand access.
 Assumes a sequencer giving events and load/store requests synchronous
 to clk_sys_i, an external bus with a level ack, and an AXI4-Lite master.
*/
// Local design decisions: the AXI4-Lite slave port and the register addresses.
// What this block does
// - Byte, word and longword operand sizes
// - Narrow loads sign-extend to 32 bits
// - Word needs 2n, longword 4n, else error
// - Byte order sampled at power-on reset only
// - Pin low big-endian, high little-endian
// - Bit 31 most significant, bit 0 least
// - 64-bit halves not converted, no swap in either order
// - Reset pin low; select picks reset kind
// - Manual reset spares the bus controller
// - Restart fetch at fixed reset vector
// - Exception saves PC, status, register 15
// - Branch to vector base plus offset
// - Halt enters sleep or standby power-down
// - Grant bus, stay released while requested
// - Mode bit 0 user, 1 privileged
// - Reset/exception set mode; return clears it
// - Protected register writes refused in user mode; reads allowed
// - Vector base resets to zero
// - Block bit masks irqs; exception forces reset unless user break
`timescale 1ns/1ps
module csm_core #(
    parameter logic [31:0] RST_VECTOR = csm_pkg::RST_VEC,
    parameter logic [31:0] ADDR_ERR_VEC = csm_pkg::ADDR_ERR_OFF
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic reset_req_n_i,
    input wire logic reset_kind_select_i,
    input wire logic endian_select_pin_i,
    input wire logic bus_req_i,
    input wire logic exc_req_i,
    input wire logic exc_user_brk_i,
    input wire logic [31:0] exc_off_i,
    input wire logic irq_req_i,
    input wire logic [31:0] irq_off_i,
    input wire logic rte_i,
    input wire logic halt_i,
    input wire logic halt_standby_i,
    input wire logic [31:0] pc_i,
    input wire logic [31:0] general_register_15_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [1:0] mem_size_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    input wire logic ext_ack_i,
    input wire logic [31:0] ext_rdata_i,
    input wire logic s_axi_awvalid,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_rready,
    output logic s_axi_awready,
    output logic s_axi_wready,
    output logic s_axi_bvalid,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_arready,
    output logic s_axi_rvalid,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic ext_req_o,
    output logic ext_we_o,
    output logic [31:0] ext_addr_o,
    output logic [3:0] ext_be_o,
    output logic [31:0] ext_wdata_o,
    output logic mem_done_o,
    output logic addr_err_o,
    output logic [31:0] ld_data_o,
    output logic fetch_load_o,
    output logic [31:0] fetch_addr_o,
    output logic [5:0] cpu_state_o,
    output logic priv_mode_o,
    output logic little_endian_o,
    output logic periph_rst_o,
    output logic bus_ctl_rst_o,
    output logic bus_grant_o
);
    generate
        if (RST_VECTOR[1:0] != 2'h0 || ADDR_ERR_VEC[1:0] != 2'h0) begin : g_chk
            $error("Vectors must be longword aligned");
        end
    endgenerate

    csm_pkg::csm_state_e st_r, st_nxt;
    logic [31:0] sw_r, vbase_r, savpc_r, savsw_r, savgr_r;
    logic [31:0] a_r, wmask, vec_w;
    logic [1:0] sz_r;
    logic busy_r, por_r, take_w, gen_exc_w, irq_w, blk_fault_w;
    logic exc_take_w, rte_w, free_w, wr_w, rd_w, sw_wr, wr_ok;
    logic [1:0] wr_resp;

    csm_fmt_if fi ();
    csm_fmt u_fmt (
        .f(fi)
    );

    assign fi.size = busy_r ? sz_r : mem_size_i;
    assign fi.addr = busy_r ? a_r : mem_addr_i;
    assign fi.wdata = mem_wdata_i;
    assign fi.bus_rdata = ext_rdata_i;
    assign fi.little = little_endian_o;

    assign free_w = st_r == csm_pkg::ST_RUN && !busy_r;
    // A done or error pulse blocks retaking the request still held
    assign take_w = mem_req_i && free_w && !mem_done_o && !addr_err_o;
    assign gen_exc_w = free_w && (exc_req_i || (take_w && fi.misalign));
    assign irq_w = irq_req_i && !sw_r[csm_pkg::BLK_BIT]
        && (free_w || st_r == csm_pkg::ST_SLEEP || st_r == csm_pkg::ST_STBY);
    assign blk_fault_w = gen_exc_w && sw_r[csm_pkg::BLK_BIT] && !exc_user_brk_i;
    assign exc_take_w = (gen_exc_w && !blk_fault_w) || (irq_w && !gen_exc_w);
    assign rte_w = free_w && rte_i && !exc_take_w && !blk_fault_w;
    assign vec_w = vbase_r + (gen_exc_w ? (exc_req_i ? exc_off_i : ADDR_ERR_VEC)
        : irq_off_i);

    always_comb begin
        st_nxt = st_r;
        if (!reset_req_n_i) begin
            st_nxt = csm_pkg::ST_RESET;
        end else begin
            unique case (st_r)
                csm_pkg::ST_RESET: st_nxt = csm_pkg::ST_RUN;
                csm_pkg::ST_EXC: st_nxt = csm_pkg::ST_RUN;
                csm_pkg::ST_RUN: begin
                    if (blk_fault_w) begin
                        st_nxt = csm_pkg::ST_RESET;
                    end else if (exc_take_w) begin
                        st_nxt = csm_pkg::ST_EXC;
                    end else if (halt_i && free_w && !rte_i) begin
                        st_nxt = halt_standby_i ? csm_pkg::ST_STBY : csm_pkg::ST_SLEEP;
                    end else if (bus_req_i && free_w && !rte_i && !mem_req_i) begin
                        st_nxt = csm_pkg::ST_BUSREL;
                    end
                end
                csm_pkg::ST_SLEEP, csm_pkg::ST_STBY: begin
                    if (irq_w) begin
                        st_nxt = csm_pkg::ST_EXC;
                    end
                end
                csm_pkg::ST_BUSREL: begin
                    if (!bus_req_i) begin
                        st_nxt = csm_pkg::ST_RUN;
                    end
                end
                default: st_nxt = csm_pkg::ST_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= csm_pkg::ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign cpu_state_o = st_r;

    // reset kind, bus controller spared on manual reset
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            por_r <= 1'b1;
            periph_rst_o <= 1'b1;
            bus_ctl_rst_o <= 1'b1;
        end else begin
            por_r <= !reset_req_n_i ? reset_kind_select_i
                : (blk_fault_w ? 1'b0 : por_r);
            periph_rst_o <= st_nxt == csm_pkg::ST_RESET;
            bus_ctl_rst_o <= !reset_req_n_i && reset_kind_select_i;
        end
    end

    // sampled only in power-on reset; high means little order
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            little_endian_o <= 1'b0;
        end else if (!reset_req_n_i && reset_kind_select_i) begin
            little_endian_o <= endian_select_pin_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_grant_o <= 1'b0;
            fetch_load_o <= 1'b0;
            fetch_addr_o <= RST_VECTOR;
        end else begin
            bus_grant_o <= st_nxt == csm_pkg::ST_BUSREL;
            fetch_load_o <= 1'b0;
            if (st_r == csm_pkg::ST_RESET && st_nxt != csm_pkg::ST_RESET) begin
                fetch_load_o <= 1'b1;
                fetch_addr_o <= RST_VECTOR;
            end else if (exc_take_w && reset_req_n_i) begin
                fetch_load_o <= 1'b1;
                fetch_addr_o <= {vec_w[31:2], 2'h0};
            end
        end
    end

    // Status word: hardware events win over a software write
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_r <= csm_pkg::SW_RST;
        end else if (st_nxt == csm_pkg::ST_RESET) begin
            sw_r <= csm_pkg::SW_RST;
        end else if (exc_take_w) begin
            sw_r[csm_pkg::MODE_BIT] <= 1'b1;
            sw_r[csm_pkg::BLK_BIT] <= 1'b1;
        end else if (rte_w) begin
            sw_r[csm_pkg::MODE_BIT] <= 1'b0;
            sw_r[csm_pkg::BLK_BIT] <= 1'b0;
        end else if (sw_wr && s_axi_awaddr == csm_pkg::REG_SW) begin
            sw_r <= (sw_r & ~wmask) | (s_axi_wdata & wmask);
        end
    end
    assign priv_mode_o = sw_r[csm_pkg::MODE_BIT];

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            savpc_r <= 32'h0000_0000;
            savsw_r <= 32'h0000_0000;
            savgr_r <= 32'h0000_0000;
        end else if (exc_take_w && reset_req_n_i) begin
            savpc_r <= pc_i;
            savsw_r <= sw_r;
            savgr_r <= general_register_15_i;
        end else if (sw_wr) begin
            if (s_axi_awaddr == csm_pkg::REG_SAVPC) begin
                savpc_r <= (savpc_r & ~wmask) | (s_axi_wdata & wmask);
            end
            if (s_axi_awaddr == csm_pkg::REG_SAVSW) begin
                savsw_r <= (savsw_r & ~wmask) | (s_axi_wdata & wmask);
            end
            if (s_axi_awaddr == csm_pkg::REG_SAVGR) begin
                savgr_r <= (savgr_r & ~wmask) | (s_axi_wdata & wmask);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vbase_r <= csm_pkg::VBASE_INIT;
        end else if (st_nxt == csm_pkg::ST_RESET) begin
            vbase_r <= csm_pkg::VBASE_INIT;
        end else if (sw_wr && s_axi_awaddr == csm_pkg::REG_VBASE) begin
            vbase_r <= (vbase_r & ~wmask) | (s_axi_wdata & wmask);
        end
    end

    // Load/store path; the request must hold until done or error
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_r <= 1'b0;
            ext_req_o <= 1'b0;
            ext_we_o <= 1'b0;
            ext_addr_o <= 32'h0000_0000;
            ext_be_o <= 4'h0;
            ext_wdata_o <= 32'h0000_0000;
            a_r <= 32'h0000_0000;
            sz_r <= csm_pkg::SZ_BYTE;
            mem_done_o <= 1'b0;
            addr_err_o <= 1'b0;
            ld_data_o <= 32'h0000_0000;
        end else begin
            mem_done_o <= 1'b0;
            addr_err_o <= 1'b0;
            if (take_w && fi.misalign) begin
                addr_err_o <= 1'b1;
            end else if (take_w && !blk_fault_w && !exc_take_w) begin
                busy_r <= 1'b1;
                ext_req_o <= 1'b1;
                ext_we_o <= mem_we_i;
                ext_addr_o <= {mem_addr_i[31:2], 2'h0};
                ext_be_o <= fi.be;
                ext_wdata_o <= fi.lane_wdata;
                a_r <= mem_addr_i;
                sz_r <= mem_size_i;
            end else if (busy_r && ext_ack_i) begin
                busy_r <= 1'b0;
                ext_req_o <= 1'b0;
                mem_done_o <= 1'b1;
                if (!ext_we_o) begin
                    ld_data_o <= fi.ld_data;
                end
            end
        end
    end

    // Register bus
    assign wr_w = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    assign rd_w = s_axi_arready && s_axi_arvalid;
    for (genvar b = 0; b < 4; b++) begin : g_strb
        assign wmask[8*b +: 8] = {8{s_axi_wstrb[b]}};
    end

    always_comb begin
        wr_resp = csm_pkg::RESP_OKAY;
        wr_ok = 1'b0;
        unique case (s_axi_awaddr)
            csm_pkg::REG_CTRL, csm_pkg::REG_PC: wr_resp = csm_pkg::RESP_OKAY;
            csm_pkg::REG_SW, csm_pkg::REG_VBASE, csm_pkg::REG_SAVPC,
            csm_pkg::REG_SAVSW, csm_pkg::REG_SAVGR: begin
                wr_ok = priv_mode_o;
                wr_resp = priv_mode_o ? csm_pkg::RESP_OKAY : csm_pkg::RESP_SLVERR;
            end
            default: wr_resp = csm_pkg::RESP_DECERR;
        endcase
    end
    assign sw_wr = wr_w && wr_ok;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_awready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= csm_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                && !s_axi_bvalid;
            if (wr_w) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_resp;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_wready = s_axi_awready;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= csm_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_w) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= csm_pkg::RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                unique case (s_axi_araddr)
                    csm_pkg::REG_CTRL: begin
                        s_axi_rdata[5:0] <= st_r;
                        s_axi_rdata[csm_pkg::CTL_KIND_BIT] <= por_r;
                        s_axi_rdata[csm_pkg::CTL_END_BIT] <= little_endian_o;
                    end
                    csm_pkg::REG_SW: s_axi_rdata <= sw_r;
                    csm_pkg::REG_VBASE: s_axi_rdata <= vbase_r;
                    csm_pkg::REG_SAVPC: s_axi_rdata <= savpc_r;
                    csm_pkg::REG_SAVSW: s_axi_rdata <= savsw_r;
                    csm_pkg::REG_SAVGR: s_axi_rdata <= savgr_r;
                    csm_pkg::REG_PC: s_axi_rdata <= fetch_addr_o;
                    default: s_axi_rresp <= csm_pkg::RESP_DECERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sign_ext_a: assert property (
        mem_done_o && !ext_we_o && sz_r == csm_pkg::SZ_BYTE
        |-> ld_data_o[31:8] == {24{ld_data_o[7]}})
        else $error("Byte load not sign extended");
    align_err_a: assert property (
        take_w && fi.misalign |=> addr_err_o && !ext_req_o)
        else $error("Misaligned access reached the bus");
    endian_hold_a: assert property (
        reset_req_n_i && $past(reset_req_n_i) |-> $stable(little_endian_o))
        else $error("Byte order changed while running");
    rst_vector_a: assert property (
        st_r == csm_pkg::ST_RESET && reset_req_n_i
        |=> fetch_load_o && fetch_addr_o == RST_VECTOR)
        else $error("Reset did not restart at vector");
    ctx_save_a: assert property (
        exc_take_w && reset_req_n_i |=> savpc_r == $past(pc_i)
        && savgr_r == $past(general_register_15_i) && savsw_r == $past(sw_r))
        else $error("Context not saved");
    vec_branch_a: assert property (
        exc_take_w && reset_req_n_i
        |=> fetch_load_o && st_r == csm_pkg::ST_EXC ##1 st_r == csm_pkg::ST_RUN)
        else $error("Vector branch missing");
    mode_set_a: assert property (
        (exc_take_w || !reset_req_n_i) |=> priv_mode_o)
        else $error("Mode bit not set on entry");
    mode_clr_a: assert property (
        rte_w && reset_req_n_i |=> !priv_mode_o)
        else $error("Mode bit not cleared on return");
    block_rst_a: assert property (
        blk_fault_w |=> st_r == csm_pkg::ST_RESET ##1 fetch_load_o)
        else $error("Blocked exception did not reset");
    bus_rel_a: assert property (
        st_r == csm_pkg::ST_BUSREL && bus_req_i && reset_req_n_i
        |=> bus_grant_o && st_r == csm_pkg::ST_BUSREL)
        else $error("Bus taken back while requested");
    user_deny_a: assert property (
        wr_w && !priv_mode_o && s_axi_awaddr == csm_pkg::REG_VBASE
        |=> s_axi_bresp == csm_pkg::RESP_SLVERR && $stable(vbase_r))
        else $error("User write to protected register");

    exc_entry_c: cover property (exc_take_w ##2 st_r == csm_pkg::ST_RUN);
    addr_err_c: cover property (addr_err_o);
    bus_rel_c: cover property (st_r == csm_pkg::ST_BUSREL [*3]);
    sleep_wake_c: cover property (st_r == csm_pkg::ST_SLEEP ##1 st_r == csm_pkg::ST_EXC);
endmodule

// file: core/csm_fmt.sv
/*
 Operand formatter: alignment check, byte lanes, sign extension.
 Assumes a 32-bit bus with lane 0 in bits 7:0.
*/
`timescale 1ns/1ps
module csm_fmt (
    csm_fmt_if.fmt f
);
    logic [1:0] lane;
    logic [3:0] mask;
    logic [4:0] sh;
    logic [31:0] rsh;

    always_comb begin
        lane = 2'h0;
        mask = 4'hF;
        f.misalign = 1'b0;
        unique case (f.size)
            csm_pkg::SZ_BYTE: begin
                mask = 4'h1;
                lane = f.little ? f.addr[1:0] : ~f.addr[1:0];
            end
            csm_pkg::SZ_WORD: begin
                mask = 4'h3;
                f.misalign = f.addr[0];
                lane = {f.little ? f.addr[1] : ~f.addr[1], 1'b0};
            end
            csm_pkg::SZ_LONG: begin
                f.misalign = |f.addr[1:0];
            end
            // no conversion, halves not swapped in either order
            csm_pkg::SZ_DBL: begin
                f.misalign = |f.addr[1:0];
            end
        endcase
        // bit 31 on top, lane 0 in bits 7:0
        sh = {lane, 3'h0};
        f.be = mask << lane;
        f.lane_wdata = f.wdata << sh;
        rsh = f.bus_rdata >> sh;
        if (f.size == csm_pkg::SZ_BYTE) begin
            f.ld_data = {{24{rsh[7]}}, rsh[7:0]};
        end else if (f.size == csm_pkg::SZ_WORD) begin
            f.ld_data = {{16{rsh[15]}}, rsh[15:0]};
        end else begin
            f.ld_data = rsh;
        end
    end
endmodule

// file: include/csm_fmt_if.sv
/*
 Signals between the core and its operand formatter.
 Assumes the formatter is purely combinational.
*/
`timescale 1ns/1ps
interface csm_fmt_if;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] bus_rdata;
    logic little;
    logic misalign;
    logic [3:0] be;
    logic [31:0] lane_wdata;
    logic [31:0] ld_data;

    modport core (
        output size, addr, wdata, bus_rdata, little,
        input misalign, be, lane_wdata, ld_data
    );
    modport fmt (
        input size, addr, wdata, bus_rdata, little,
        output misalign, be, lane_wdata, ld_data
    );
endinterface

// file: include/csm_pkg.sv
/*
 Shared constants for the CPU state, mode and operand format core.
 Assumes nothing of its surroundings; holds definitions only.
*/
package csm_pkg;

    // Fixed restart address after any reset
    localparam logic [31:0] RST_VEC = 32'hA000_0000;
    localparam logic [31:0] VBASE_INIT = 32'h0000_0000;
    // Vector offset used for a misaligned operand
    localparam logic [31:0] ADDR_ERR_OFF = 32'h0000_0100;

    // Status word fields
    localparam int MODE_BIT = 30;
    localparam int BLK_BIT = 28;
    localparam logic [31:0] SW_RST = 32'h5000_0000;

    // Operand sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] SZ_DBL = 2'h3;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SW = 8'h04;
    localparam logic [7:0] REG_VBASE = 8'h08;
    localparam logic [7:0] REG_SAVPC = 8'h0C;
    localparam logic [7:0] REG_SAVSW = 8'h10;
    localparam logic [7:0] REG_SAVGR = 8'h14;
    localparam logic [7:0] REG_PC = 8'h18;

    // Control register read fields
    localparam int CTL_KIND_BIT = 8;
    localparam int CTL_END_BIT = 9;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [5:0] {
        ST_RESET = 6'h01,
        ST_EXC = 6'h02,
        ST_RUN = 6'h04,
        ST_SLEEP = 6'h08,
        ST_STBY = 6'h10,
        ST_BUSREL = 6'h20
    } csm_state_e;

endpackage

// file: testbench/csm_bus_model.sv
/* External bus responder for the core's load/store port.
   Assumes a level request held by the core until a one-cycle ack. */
`timescale 1ns/1ps
module csm_bus_model #(
    parameter logic [31:0] RD_WORD = 32'h1234_8001
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ext_req_i,
    output logic ext_ack_o,
    output logic [31:0] ext_rdata_o
);
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_ack_o <= 1'b0;
        end else begin
            ext_ack_o <= ext_req_i & ~ext_ack_o;
        end
    end
    // Inverted outside ack so a late sample never matches
    assign ext_rdata_o = ext_ack_o ? RD_WORD : ~RD_WORD;
endmodule

// file: testbench/test_csm_core.sv
/* Self-checking bench for the state, mode and operand core.
   Assumes the bus responder model and the design package. */
`timescale 1ns/1ps
module test_csm_core;
    logic clk_sys_i = 0, rst_n_i = 0, reset_req_n_i = 1, reset_kind_select_i = 1;
    logic endian_select_pin_i = 0, bus_req_i = 0, exc_req_i = 0, exc_user_brk_i = 0;
    logic irq_req_i = 0, rte_i = 0, halt_i = 0, halt_standby_i = 0, mem_req_i = 0;
    logic mem_we_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, ext_ack_i;
    logic [1:0] mem_size_i = 0, s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'hF, ext_be_o;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] exc_off_i = 0, irq_off_i = 0, pc_i = 0, general_register_15_i = 0;
    logic [31:0] mem_addr_i = 0, mem_wdata_i = 0, s_axi_wdata = 0, ext_rdata_i;
    logic [31:0] s_axi_rdata, ext_addr_o, ext_wdata_o, ld_data_o, fetch_addr_o;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic ext_req_o, ext_we_o, mem_done_o, addr_err_o, fetch_load_o, priv_mode_o;
    logic little_endian_o, periph_rst_o, bus_ctl_rst_o, bus_grant_o;
    logic [5:0] cpu_state_o;
    logic [1:0] rsp;
    logic [31:0] rd;
    int mismatches = 0, total_checks = 0, cyc = 0;
    csm_core dut (.*);
    csm_bus_model bus (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ext_req_i(ext_req_o),
        .ext_ack_o(ext_ack_i), .ext_rdata_o(ext_rdata_i));
    always #2.5 clk_sys_i = ~clk_sys_i;
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Generous ceiling; the whole sequence needs well under two hundred cycles
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_bready <= 1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp; s_axi_bready <= 0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clk_sys_i);
        s_axi_arvalid <= 1; s_axi_araddr <= a; s_axi_rready <= 1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata; rsp = s_axi_rresp; s_axi_rready <= 0;
    endtask
    task automatic mem(input logic we, input logic [1:0] sz, input logic [31:0] a,
        input logic [3:0] be, input logic [31:0] exp);
        @(posedge clk_sys_i);
        mem_req_i <= 1; mem_we_i <= we; mem_size_i <= sz; mem_addr_i <= a;
        mem_wdata_i <= 32'h0000_00A5;
        do @(posedge clk_sys_i); while (!ext_req_o);
        chk({27'h0, ext_we_o, ext_be_o}, {27'h0, we, be});
        if (we) chk(ext_wdata_o, exp);
        do @(posedge clk_sys_i); while (!mem_done_o);
        mem_req_i <= 0;
        if (!we) chk(ld_data_o, exp);
    endtask
    task automatic t_misalign();
        logic bad = 0;
        @(posedge clk_sys_i);
        mem_req_i <= 1; mem_we_i <= 0; mem_size_i <= csm_pkg::SZ_LONG;
        mem_addr_i <= 32'h0000_0102;
        do begin
            @(posedge clk_sys_i);
            bad |= ext_req_o;
        end while (!addr_err_o);
        mem_req_i <= 0;
        chk({31'h0, bad}, 32'h0000_0000);
        chk(fetch_addr_o, csm_pkg::ADDR_ERR_OFF);
    endtask
    task automatic t_rte();
        @(posedge clk_sys_i) rte_i <= 1;
        @(posedge clk_sys_i) rte_i <= 0;
        @(posedge clk_sys_i) #1;
        chk({31'h0, priv_mode_o}, 32'h0000_0000);
    endtask
    task automatic t_exc();
        @(posedge clk_sys_i);
        pc_i <= 32'h8C00_1230; general_register_15_i <= 32'h8C0F_FFF0;
        exc_off_i <= 32'h0000_0400; exc_req_i <= 1;
        @(posedge clk_sys_i) exc_req_i <= 0;
        do @(posedge clk_sys_i); while (!fetch_load_o);
        chk(fetch_addr_o, 32'h0000_0400);
        chk({31'h0, priv_mode_o}, 32'h0000_0001);
        axr(csm_pkg::REG_SAVPC); chk(rd, 32'h8C00_1230);
        axr(csm_pkg::REG_SAVGR); chk(rd, 32'h8C0F_FFF0);
        axr(csm_pkg::REG_SAVSW); chk(rd, 32'h0000_0000);
    endtask
    task automatic t_user();
        axw(csm_pkg::REG_VBASE, 32'h0000_1000); chk({30'h0, rsp}, 32'h0000_0002);
        axw(8'h40, 32'h0000_0001); chk({30'h0, rsp}, 32'h0000_0003);
        axr(8'h40); chk({30'h0, rsp}, 32'h0000_0003);
        axr(csm_pkg::REG_VBASE); chk(rd, csm_pkg::VBASE_INIT);
    endtask
    task automatic t_halt();
        @(posedge clk_sys_i);
        halt_i <= 1; irq_off_i <= 32'h0000_0600;
        @(posedge clk_sys_i) halt_i <= 0;
        @(posedge clk_sys_i) #1;
        chk({26'h0, cpu_state_o}, {26'h0, csm_pkg::ST_SLEEP});
        @(posedge clk_sys_i) irq_req_i <= 1;
        do @(posedge clk_sys_i); while (!fetch_load_o);
        irq_req_i <= 0; exc_req_i <= 1;
        chk(fetch_addr_o, 32'h0000_0600);
        @(posedge clk_sys_i) exc_req_i <= 0;
        do @(posedge clk_sys_i); while (!fetch_load_o);
        chk(fetch_addr_o, csm_pkg::RST_VEC);
    endtask
    task automatic t_bus();
        @(posedge clk_sys_i) bus_req_i <= 1;
        do @(posedge clk_sys_i); while (!bus_grant_o);
        chk({26'h0, cpu_state_o}, {26'h0, csm_pkg::ST_BUSREL});
        bus_req_i <= 0;
        do @(posedge clk_sys_i); while (bus_grant_o);
    endtask
    task automatic t_rst(input logic kind, input logic pin, input logic bc, input logic le);
        @(posedge clk_sys_i);
        reset_req_n_i <= 0; reset_kind_select_i <= kind; endian_select_pin_i <= pin;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({26'h0, cpu_state_o}, {26'h0, csm_pkg::ST_RESET});
        chk({30'h0, bus_ctl_rst_o, periph_rst_o}, {30'h0, bc, 1'b1});
        @(posedge clk_sys_i) reset_req_n_i <= 1;
        do @(posedge clk_sys_i); while (!fetch_load_o);
        endian_select_pin_i <= ~pin;
        chk(fetch_addr_o, csm_pkg::RST_VEC);
        chk({30'h0, priv_mode_o, little_endian_o}, {30'h0, 1'b1, le});
    endtask
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1;
        do @(posedge clk_sys_i); while (!fetch_load_o);
        chk(fetch_addr_o, csm_pkg::RST_VEC);
        mem(1, csm_pkg::SZ_BYTE, 32'h0000_0001, 4'h4, 32'h00A5_0000);
        mem(0, csm_pkg::SZ_WORD, 32'h0000_0002, 4'h3, 32'hFFFF_8001);
        mem(0, csm_pkg::SZ_BYTE, 32'h0000_0002, 4'h2, 32'hFFFF_FF80);
        t_rte();
        t_misalign();
        t_rte();
        t_exc();
        t_rte();
        t_user();
        t_halt();
        t_bus();
        t_rst(0, 1, 0, 0);
        t_rst(1, 1, 1, 1);
        mem(0, csm_pkg::SZ_WORD, 32'h0000_0002, 4'hC, 32'h0000_1234);
        mem(0, csm_pkg::SZ_DBL, 32'h0000_0000, 4'hF, 32'h1234_8001);
        report_and_stop();
    end
endmodule
